// ==== src/gp_pkg.sv ====
// Purpose: shared constants for the general-purpose pin port
// Assumes: single core clock, synchronous active-high reset
// Notes: bit n of every word belongs to pin n
// How it works
// [RQ1] 28 pins, all inputs during reset
// [RQ2] direction bit per pin selects in/out
// [RQ3] set/clear writes feed hidden output latch
// [RQ4] set/clear accepted for input pins too
// [RQ5] latch shows immediately when pin becomes output
// [RQ6] pin level readable at any time
// [RQ7] output pins read back actual level
// [RQ8] rising/falling/both edge selects per pin
// [RQ9] edge status readable by software
// [RQ10] edges go to interrupts and wake-up
// [RQ11] sleep entry loads latch from sleep state
// [RQ12] outputs drive sleep values before sleep
// [RQ13] sleep values stay until set/clear write
// [RQ14] alternate functions fixed to their pins
// [RQ15] alternate pins still use direction register
// [RQ16] bit n is pin n, 31..28 zero
// [RQ17] direction one output, hard reset clears
// [RQ18] ones set/clear, zeros leave unchanged
// [RQ19] pin inputs synchronised before sampling
package gp_pkg;
    localparam int unsigned NUM_PINS = 28;
    localparam int unsigned REG_W = 32;
    localparam int unsigned RSVD_W = REG_W - NUM_PINS;
    localparam logic [NUM_PINS-1:0] DIR_RESET = 28'h0000000;
    localparam logic [NUM_PINS-1:0] ALL_ZERO = 28'h0000000;
    localparam logic [RSVD_W-1:0] RSVD_ZERO = 4'h0;
endpackage

// ==== src/gp_edge_if.sv ====
// Purpose: carries synchronised levels and edge pulses between port modules
// Assumes: widths set by gp_pkg
// Notes: edge module drives level and pulses, the port drives selects
interface gp_edge_if;
    logic [gp_pkg::NUM_PINS-1:0] level;
    logic [gp_pkg::NUM_PINS-1:0] rise_sel;
    logic [gp_pkg::NUM_PINS-1:0] fall_sel;
    logic [gp_pkg::NUM_PINS-1:0] edge_hit;
    modport det (output level, output edge_hit, input rise_sel, input fall_sel);
    modport port (input level, input edge_hit, output rise_sel, output fall_sel);
endinterface

// ==== src/gp_edge_det.sv ====
// Purpose: synchronise pin inputs and flag selected edges
// Assumes: pins are asynchronous to the core clock
// Notes: edge_hit is a one-cycle pulse, level is the synchronised pin
module gp_edge_det (
    input wire logic i_core_clk,                       // core clock
    input wire logic i_rst,                            // sync reset, active high
    input wire logic i_ce,                             // clock enable
    input wire logic [gp_pkg::NUM_PINS-1:0] i_pin_in,  // raw pin levels
    gp_edge_if.det eif                                 // levels and edges
);
    logic [gp_pkg::NUM_PINS-1:0] meta_ff, sync_ff, prev_ff;
    logic [gp_pkg::NUM_PINS-1:0] hit_ff;
    logic [gp_pkg::NUM_PINS-1:0] nxt_meta, nxt_sync, nxt_prev, nxt_hit;

    // only sync_ff reads meta_ff, so a metastable sample never reaches the edge logic
    always_comb begin
        nxt_meta = i_pin_in;      // RQ19
        nxt_sync = meta_ff;       // RQ19
        nxt_prev = sync_ff;
        nxt_hit = (eif.rise_sel & sync_ff & ~prev_ff)
                | (eif.fall_sel & ~sync_ff & prev_ff); // RQ8
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            meta_ff <= gp_pkg::ALL_ZERO;
            sync_ff <= gp_pkg::ALL_ZERO;
            prev_ff <= gp_pkg::ALL_ZERO;
            hit_ff <= gp_pkg::ALL_ZERO;
        end else if (i_ce) begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
            hit_ff <= nxt_hit;
        end
    end

    assign eif.level = sync_ff;
    // prev starts at zero, so a pin high at reset release shows one rising edge
    assign eif.edge_hit = hit_ff & {gp_pkg::NUM_PINS{i_ce}};
endmodule

// ==== src/gp_port.sv ====
// Purpose: 28-pin general-purpose port with direction, set/clear and edge status
// Assumes: register accesses arrive as one-cycle write strobes with data
// Notes: the output latch has no read path; sleep load takes priority over writes
module gp_port (
    input wire logic i_core_clk,                             // core clock 20 MHz
    input wire logic i_rst,                                  // hard reset, sync, active high
    input wire logic i_ce,                                   // clock enable, freezes state
    input wire logic [gp_pkg::NUM_PINS-1:0] i_pin_in,        // pin levels from pads
    input wire logic i_dir_wr,                               // pin_direction_reg write
    input wire logic [gp_pkg::NUM_PINS-1:0] i_dir_wdata,     // direction data, 1 = output
    input wire logic i_set_wr,                               // output_set_reg write
    input wire logic [gp_pkg::NUM_PINS-1:0] i_set_wdata,     // ones drive pins high
    input wire logic i_clr_wr,                               // output_clear_reg write
    input wire logic [gp_pkg::NUM_PINS-1:0] i_clr_wdata,     // ones drive pins low
    input wire logic i_rise_wr,                              // rising_edge_select_reg write
    input wire logic [gp_pkg::NUM_PINS-1:0] i_rise_wdata,    // rising select data
    input wire logic i_fall_wr,                              // falling_edge_select_reg write
    input wire logic [gp_pkg::NUM_PINS-1:0] i_fall_wdata,    // falling select data
    input wire logic i_edge_clr_wr,                          // edge status write, one clears
    input wire logic [gp_pkg::NUM_PINS-1:0] i_edge_clr_wdata, // ones clear status bits
    input wire logic i_sleep_enter,                          // sleep entry pulse
    input wire logic [gp_pkg::NUM_PINS-1:0] i_sleep_state,   // sleep_output_state_reg value
    input wire logic [gp_pkg::NUM_PINS-1:0] i_alt_en,        // alternate function owns pin n
    input wire logic [gp_pkg::NUM_PINS-1:0] i_alt_out,       // alternate function output bit n
    output logic [gp_pkg::REG_W-1:0] o_pin_level,            // pin_level_reg read value
    output logic [gp_pkg::REG_W-1:0] o_dir,                  // pin_direction_reg read value
    output logic [gp_pkg::REG_W-1:0] o_rise_sel,             // rising select read value
    output logic [gp_pkg::REG_W-1:0] o_fall_sel,             // falling select read value
    output logic [gp_pkg::REG_W-1:0] o_edge_status,          // edge_detect_status_reg read
    output logic [gp_pkg::NUM_PINS-1:0] o_edge_irq,          // per-pin interrupt request level
    output logic o_wake,                                     // any edge pending, wake request
    output logic [gp_pkg::NUM_PINS-1:0] o_pin_out,           // pad output data
    output logic [gp_pkg::NUM_PINS-1:0] o_pin_oe,            // pad output enable, high drives
    output logic o_sleep_ready                               // sleep values on pads
);
    localparam int unsigned N = gp_pkg::NUM_PINS;

    gp_edge_if eif ();

    gp_edge_det u_det (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_pin_in(i_pin_in),
        .eif(eif)
    );

    // configuration group
    logic [N-1:0] dir_ff, rise_ff, fall_ff;
    logic [N-1:0] nxt_dir, nxt_rise, nxt_fall;

    always_comb begin
        nxt_dir = i_dir_wr ? i_dir_wdata : dir_ff;       // RQ2
        nxt_rise = i_rise_wr ? i_rise_wdata : rise_ff;   // RQ8
        nxt_fall = i_fall_wr ? i_fall_wdata : fall_ff;   // RQ8
    end

    // hard reset only; there is no soft or sleep reset input here
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            dir_ff <= gp_pkg::DIR_RESET;     // RQ1 RQ17
            rise_ff <= gp_pkg::ALL_ZERO;
            fall_ff <= gp_pkg::ALL_ZERO;
        end else if (i_ce) begin
            dir_ff <= nxt_dir;
            rise_ff <= nxt_rise;
            fall_ff <= nxt_fall;
        end
    end

    assign eif.rise_sel = rise_ff;
    assign eif.fall_sel = fall_ff;

    // output latch group; no read path exists for it
    logic [N-1:0] latch_ff, nxt_latch;
    logic sleep_ready_ff, nxt_sleep_ready;

    always_comb begin
        nxt_latch = latch_ff;
        // write does not look at direction, so input pins accept it too
        if (i_set_wr) begin
            nxt_latch = nxt_latch | i_set_wdata;    // RQ3 RQ4 RQ18
        end
        // clear applied after set: a pin in both words ends low
        if (i_clr_wr) begin
            nxt_latch = nxt_latch & ~i_clr_wdata;   // RQ3 RQ4 RQ18
        end
        // sleep value overrides writes and then simply stays
        if (i_sleep_enter) begin
            nxt_latch = i_sleep_state;              // RQ11 RQ13
        end
        nxt_sleep_ready = i_sleep_enter;            // RQ12
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            latch_ff <= gp_pkg::ALL_ZERO;
            sleep_ready_ff <= 1'b0;
        end else if (i_ce) begin
            latch_ff <= nxt_latch;
            sleep_ready_ff <= nxt_sleep_ready;
        end
    end

    // pad group, registered so every pad output comes from a flop
    logic [N-1:0] out_ff, oe_ff, nxt_out, nxt_oe;

    // alternate functions are hardwired one per pin, never remapped
    for (genvar g = 0; g < N; g++) begin : g_pad
        always_comb begin
            nxt_oe[g] = nxt_dir[g];                                          // RQ15 RQ17
            nxt_out[g] = i_alt_en[g] ? i_alt_out[g] : nxt_latch[g];          // RQ5 RQ14
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            out_ff <= gp_pkg::ALL_ZERO;
            oe_ff <= gp_pkg::ALL_ZERO;       // RQ1
        end else if (i_ce) begin
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
        end
    end

    // status group
    logic [N-1:0] status_ff, nxt_status;
    logic [N-1:0] level_ff, nxt_level;
    logic wake_ff, nxt_wake;

    always_comb begin
        nxt_status = status_ff;
        if (i_edge_clr_wr) begin
            nxt_status = nxt_status & ~i_edge_clr_wdata;
        end
        // a new edge in the clearing cycle survives
        nxt_status = nxt_status | eif.edge_hit;   // RQ9
        // sampled from the synchroniser, so outputs read back their real pad level
        nxt_level = eif.level;                    // RQ6 RQ7 RQ19
        nxt_wake = |nxt_status;                   // RQ10
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            status_ff <= gp_pkg::ALL_ZERO;
            level_ff <= gp_pkg::ALL_ZERO;
            wake_ff <= 1'b0;
        end else if (i_ce) begin
            status_ff <= nxt_status;
            level_ff <= nxt_level;
            wake_ff <= nxt_wake;
        end
    end

    assign o_pin_level = {gp_pkg::RSVD_ZERO, level_ff};      // RQ16
    assign o_dir = {gp_pkg::RSVD_ZERO, dir_ff};              // RQ16
    assign o_rise_sel = {gp_pkg::RSVD_ZERO, rise_ff};
    assign o_fall_sel = {gp_pkg::RSVD_ZERO, fall_ff};
    assign o_edge_status = {gp_pkg::RSVD_ZERO, status_ff};   // RQ16
    assign o_edge_irq = status_ff;                           // RQ10
    assign o_wake = wake_ff;
    assign o_pin_out = out_ff;
    assign o_pin_oe = oe_ff;
    assign o_sleep_ready = sleep_ready_ff;
endmodule

// ==== bench/gp_pin_model.sv ====
// Purpose: application side of the pads, resolves each pin wire
// Assumes: no pull on the pads, the port wins wherever it drives
// Notes: app levels come from the bench
module gp_pin_model (
    input wire logic [gp_pkg::NUM_PINS-1:0] i_app, // application drive level
    input wire logic [gp_pkg::NUM_PINS-1:0] i_out, // port pad data
    input wire logic [gp_pkg::NUM_PINS-1:0] i_oe,  // port pad enable
    output logic [gp_pkg::NUM_PINS-1:0] o_pad      // resolved pin level
);
    timeunit 1ns;
    timeprecision 1ns;
    assign o_pad = (i_out & i_oe) | (i_app & ~i_oe);
endmodule

// ==== bench/gp_port_checker.sv ====
// Purpose: temporal checks on the pin port outputs
// Assumes: checks pause while reset is high or the clock enable is low
// Notes: edge check rebuilds the expected pulse from the level readback
module gp_port_checker (
    input wire logic i_core_clk,               // core clock
    input wire logic i_rst,                    // sync reset, active high
    input wire logic i_ce,                     // clock enable
    input wire logic i_dir_wr,                 // direction write strobe
    input wire logic i_set_wr,                 // set write strobe
    input wire logic i_clr_wr,                 // clear write strobe
    input wire logic i_sleep_enter,            // sleep entry pulse
    input wire logic o_wake,                   // wake request
    input wire logic o_sleep_ready,            // sleep values on pads
    input wire logic [27:0] i_pin_in,          // pad levels
    input wire logic [27:0] i_dir_wdata,       // direction data
    input wire logic [27:0] i_set_wdata,       // set data
    input wire logic [27:0] i_clr_wdata,       // clear data
    input wire logic [27:0] i_sleep_state,     // sleep state value
    input wire logic [27:0] i_alt_en,          // alternate function owns pin
    input wire logic [27:0] i_alt_out,         // alternate function data
    input wire logic [27:0] o_edge_irq,        // interrupt request lines
    input wire logic [27:0] o_pin_out,         // pad data
    input wire logic [27:0] o_pin_oe,          // pad enable
    input wire logic [31:0] o_pin_level,       // level readback
    input wire logic [31:0] o_dir,             // direction readback
    input wire logic [31:0] o_rise_sel,        // rising select readback
    input wire logic [31:0] o_fall_sel,        // falling select readback
    input wire logic [31:0] o_edge_status      // edge status readback
);
    logic [27:0] lv_ff, hit;
    default clocking cb @(posedge i_core_clk); endclocking
    // a frozen cycle takes no write, so every check pauses with the enable
    default disable iff (i_rst || !i_ce);
    always_ff @(posedge i_core_clk) lv_ff <= o_pin_level[27:0];
    assign hit = (o_pin_level[27:0] & ~lv_ff & o_rise_sel[27:0])
        | (~o_pin_level[27:0] & lv_ff & o_fall_sel[27:0]);
    sequence s_edge_seen; hit != 28'h0; endsequence
    sequence s_sleep; i_sleep_enter; endsequence
    a_reset_all_inputs: assert property ($past(i_rst) |-> o_dir == 32'h0 && o_pin_oe == 28'h0)
        else $error("pins not inputs after reset");
    a_dir_write: assert property (i_dir_wr |=> o_dir == {4'h0, $past(i_dir_wdata)})
        else $error("direction readback wrong");
    a_oe_from_dir: assert property (o_pin_oe == o_dir[27:0])
        else $error("pad enable differs from direction");
    a_set_bits: assert property (i_set_wr && !i_clr_wr && !i_sleep_enter |=>
        (o_pin_out & $past(i_set_wdata)) == $past(i_set_wdata)) else $error("set lost");
    a_clear_bits: assert property (i_clr_wr && !i_sleep_enter |=>
        (o_pin_out & $past(i_clr_wdata)) == 28'h0) else $error("clear lost");
    a_latch_hold: assert property (!(i_set_wr || i_clr_wr || i_sleep_enter) &&
        $stable(i_alt_en) && $stable(i_alt_out) |=> $stable(o_pin_out))
        else $error("latch moved without a write");
    a_sleep_load: assert property (s_sleep |=> o_sleep_ready && o_pin_out == $past(i_sleep_state))
        else $error("sleep values not on pads");
    a_level_sync: assert property (!($past(i_rst) || $past(i_rst, 2) || $past(i_rst, 3)) |->
        o_pin_level[27:0] == $past(i_pin_in, 3)) else $error("level latency wrong");
    a_edge_flag: assert property (s_edge_seen |=> (o_edge_status[27:0] & $past(hit)) == $past(hit))
        else $error("selected edge not flagged");
    a_irq_wake: assert property (o_edge_irq == o_edge_status[27:0] && o_wake == |o_edge_status)
        else $error("request lines differ from status");
    a_alt_pin_fixed: assert property (i_alt_en != 28'h0 |=>
        ((o_pin_out ^ $past(i_alt_out)) & $past(i_alt_en)) == 28'h0)
        else $error("alternate data not on its own pin");
endmodule

// ==== bench/test_general_purpose_io_port.sv ====
// Purpose: self-checking bench for the general-purpose pin port
// Assumes: clock enable and alternate inputs move only in their own scenarios
// Notes: only input pins toggle in the edge loop, output pins stay fixed
module test_general_purpose_io_port;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
        $display("ERROR %0t got %h want %h", $time, a, b); end end
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [6:0] st = 7'h00;
    logic [27:0] wd [7] = '{default: 28'h0};
    logic [27:0] app = 28'h0, lat, dirv, pad, p0, p1, rs, fs, es, irq, pout, poe;
    logic [31:0] lvl, dr, rsel, fsel, stat;
    logic wake, rdy;
    logic ce = 1'b1;
    logic [27:0] aen = 28'h0, aout = 28'h0;
    int fails = 0;
    int cmp_count = 0;
    initial forever #25 i_core_clk = ~i_core_clk;
    gp_pin_model pin_u (.i_app(app), .i_out(pout), .i_oe(poe), .o_pad(pad));
    gp_port dut_u (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(ce), .i_pin_in(pad),
        .i_dir_wr(st[0]), .i_dir_wdata(wd[0]), .i_set_wr(st[1]), .i_set_wdata(wd[1]),
        .i_clr_wr(st[2]), .i_clr_wdata(wd[2]), .i_rise_wr(st[3]), .i_rise_wdata(wd[3]),
        .i_fall_wr(st[4]), .i_fall_wdata(wd[4]), .i_edge_clr_wr(st[5]),
        .i_edge_clr_wdata(wd[5]), .i_sleep_enter(st[6]), .i_sleep_state(wd[6]),
        .i_alt_en(aen), .i_alt_out(aout), .o_pin_level(lvl), .o_dir(dr),
        .o_rise_sel(rsel), .o_fall_sel(fsel), .o_edge_status(stat), .o_edge_irq(irq),
        .o_wake(wake), .o_pin_out(pout), .o_pin_oe(poe), .o_sleep_ready(rdy));
    function automatic logic [27:0] rnd();
        logic [31:0] v;
        v = $urandom;
        return v[27:0];
    endfunction
    function automatic logic [27:0] f_latch(logic [27:0] l, logic [27:0] s, logic [27:0] c);
        return (l | s) & ~c;
    endfunction
    function automatic logic [27:0] f_edge(logic [27:0] a, logic [27:0] b, logic [27:0] r,
        logic [27:0] f);
        return (~a & b & r) | (a & ~b & f);
    endfunction
    // one-cycle strobe, raised and dropped on falling edges
    task automatic put(input int k, input logic [27:0] d);
        @(negedge i_core_clk);
        st[k] = 1'b1;
        wd[k] = d;
        @(negedge i_core_clk);
        st[k] = 1'b0;
    endtask
    task automatic give_verdict();
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #1000000;
        fails++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'hEC9330BB));
        repeat (20) @(negedge i_core_clk);
        i_rst = 1'b0;
        @(negedge i_core_clk);
        `CHK(poe, 28'h0)
        `CHK(dr, 32'h0)
        lat = rnd();
        put(1, lat);
        `CHK(poe, 28'h0)
        `CHK(pout, lat)
        dirv = rnd();
        put(0, dirv);
        `CHK(poe, dirv)
        `CHK(pout & poe, lat & dirv)
        put(2, 28'hFFFFFFF);
        lat = 28'h0;
        `CHK(pout, lat)
        for (int i = 0; i < 16; i++) begin
            p0 = (i == 0) ? 28'h0 : rnd();
            p1 = (i == 1) ? 28'h0 : rnd();
            put(1, p0);
            put(2, p1);
            lat = f_latch(lat, p0, p1);
            `CHK(pout, lat)
        end
        rs = rnd();
        fs = rnd();
        put(3, rs);
        put(4, fs);
        `CHK({rsel, fsel}, {4'h0, rs, 4'h0, fs})
        for (int i = 0; i < 12; i++) begin
            repeat (6) @(negedge i_core_clk);
            put(5, 28'hFFFFFFF);
            p0 = pad;
            app = (i == 0) ? ~app : rnd();
            repeat (6) @(negedge i_core_clk);
            es = f_edge(p0, pad, rs, fs);
            `CHK(lvl, {4'h0, pad})
            `CHK(stat, {4'h0, es})
            `CHK({irq, wake}, {es, |es})
        end
        lat = rnd();
        put(6, lat);
        `CHK(rdy, 1'b1)
        `CHK(pout, lat)
        `CHK(pad & dirv, lat & dirv)
        repeat (5) @(negedge i_core_clk);
        `CHK(pout, lat)
        put(1, 28'h0000001);
        lat = f_latch(lat, 28'h0000001, 28'h0);
        `CHK(pout, lat)
        // alternate data lands only on the pins that own it, direction untouched
        @(negedge i_core_clk);
        aen = rnd();
        aout = rnd();
        @(negedge i_core_clk);
        `CHK(pout, (lat & ~aen) | (aout & aen))
        `CHK(poe, dirv)
        aen = 28'h0;
        @(negedge i_core_clk);
        `CHK(pout, lat)
        // let the pads settle so the frozen pipeline holds their final level
        repeat (4) @(negedge i_core_clk);
        ce = 1'b0;
        put(0, ~dirv);
        ce = 1'b1;
        @(negedge i_core_clk);
        `CHK(dr, {4'h0, dirv})
        `CHK(poe, dirv)
        // hard reset in mid-run returns every pin to input
        i_rst = 1'b1;
        repeat (2) @(negedge i_core_clk);
        i_rst = 1'b0;
        @(negedge i_core_clk);
        `CHK(dr, 32'h0)
        `CHK(poe, 28'h0)
        give_verdict();
    end
endmodule
bind gp_port gp_port_checker chk_u (.i_core_clk, .i_rst, .i_ce, .i_dir_wr, .i_set_wr, .i_clr_wr,
    .i_sleep_enter, .o_wake, .o_sleep_ready, .i_pin_in, .i_dir_wdata, .i_set_wdata,
    .i_clr_wdata, .i_sleep_state, .i_alt_en, .i_alt_out, .o_edge_irq, .o_pin_out, .o_pin_oe,
    .o_pin_level, .o_dir, .o_rise_sel, .o_fall_sel, .o_edge_status);
